// ### shared/pulse_gen_pkg.sv
// Package: constants, modes and register map for the pulse generator and connector router
package pulse_gen_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PERIOD = 8'h04;
	localparam logic [7:0] REG_WIDTH1 = 8'h08;
	localparam logic [7:0] REG_WIDTH2 = 8'h0C;
	localparam logic [7:0] REG_DELAY2 = 8'h10;
	localparam logic [7:0] REG_CONN = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	// Control field positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_DOUBLE = 1;
	localparam int CTRL_TRIG_LO = 2;
	localparam int CTRL_EXTSRC = 4;
	localparam int CTRL_MODPOL = 5;
	localparam int CTRL_TRIGFALL = 6;
	localparam int CTRL_GATELOW = 7;
	// Connector config: conn n at bits [8n+3:8n] role, bit 8n+4 slope falling
	localparam int CONN_FIELD = 8;
	localparam int CONN_SLOPE = 4;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
	localparam logic [31:0] WIDTH1_RST = 32'h0000_000A;
	localparam logic [31:0] WIDTH2_RST = 32'h0000_000A;
	localparam logic [31:0] DELAY2_RST = 32'h0000_0032;
	localparam logic [31:0] UNMAPPED = 32'h0000_0000;
	typedef enum logic [1:0] {TRIG_AUTO, TRIG_SINGLE, TRIG_GATED, TRIG_RSVD} trig_mode_e;
	typedef enum logic [3:0] {
		ROLE_MARKER, ROLE_TRIGGER, ROLE_CLOCK, ROLE_SYNC, ROLE_NEXTSEG,
		ROLE_VALID, ROLE_TRANSIT, ROLE_VIDEO, ROLE_PGTRIG, ROLE_MODSRC, ROLE_OFF
	} conn_role_e;
	typedef struct packed {
		logic enable;
		logic doublePulse;
		trig_mode_e trigMode;
		logic extSource;
		logic modPolLow;
		logic trigFalling;
		logic gateLow;
	} pulse_ctrl_s;
	typedef struct packed {
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] width1;
		logic [CNT_W-1:0] width2;
		logic [CNT_W-1:0] delay2;
	} pulse_timing_s;
endpackage

// ### hw/pulse_core.sv
// Pulse pattern counter: single or double pulse per period
`timescale 1ns/1ps
`default_nettype none
module pulse_core #(
	parameter int CNT_W = 32
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic start,
	input wire logic doublePulse,
	input wire pulse_gen_pkg::pulse_timing_s timing,
	// Status
	output logic pulseOut,
	output logic busy
);
	logic [CNT_W-1:0] count;
	logic active;
	logic [CNT_W-1:0] next_count;
	logic lastTick;
	logic [CNT_W-1:0] pos;

	assign lastTick = (count >= timing.period - {{(CNT_W-1){1'b0}}, 1'b1});
	assign pos = (active && !lastTick) ? next_count : '0;
	assign next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};

	// Period counter; restart at period end only while start is set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= '0;
			active <= 1'b0;
		end
		else if (!run)
		begin
			count <= '0;
			active <= 1'b0;
		end
		else if (!active)
		begin
			count <= '0;
			active <= start;
		end
		else if (lastTick)
		begin
			count <= '0;
			active <= start;
		end
		else
			count <= next_count;
	end

	// Pulse level: first from period start, second after start-to-start delay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulseOut <= 1'b0;
		else if (!run)
			pulseOut <= 1'b0;
		else if (!start && (!active || lastTick))
			pulseOut <= 1'b0; // Period ends with no restart: no stray pulse
		else
		begin
			pulseOut <= (pos < timing.width1)
				|| (doublePulse && pos >= timing.delay2
				&& pos < timing.delay2 + timing.width2);
		end
	end

	assign busy = active;
endmodule // pulse_core
`default_nettype wire

// ### hw/pulse_gen_router.sv
// Pulse generator with trigger modes and two multi-purpose user connectors
// Notes on behaviour
// - Single mode gives one pulse per period; double mode gives two.
// - Pattern restarts every period while generation is active.
// - First pulse lasts the programmed width from period start.
// - External modulation polarity selects which level counts as active.
// - Second pulse has its own width, independent of the first.
// - Second pulse starts the programmed delay after the first starts.
// - Auto setting generates period after period without waiting.
// - Single trigger setting runs one sequence per active trigger edge seen while idle; edges during a sequence are ignored.
// - Gated setting pulses only while the gate is active.
// - Trigger edge selectable rising or falling, used only when triggered.
// - Gate polarity selectable, used only when gated.
// - Each connector has its own role; some roles only on connector two.
// - Marker role drives the connector with the marker signal.
// - Next-segment role turns an active edge into an advance request.
// - Valid role drives high while frequency and level are settled.
// - Transition role drives high while a change is in progress.
// - Connector two may output the internal pulse video signal.
// - Connector two may take an external trigger for the generator.
// - Connector two may take external modulation; source drives pulses there.
// - Trigger and clock roles take a selectable active edge.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_router #(
	parameter int CNT_W = 32
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [pulse_gen_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pulse_gen_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [pulse_gen_pkg::DATA_W-1:0] regRdData,
	// User connectors, output enable low while driving
	input wire logic [1:0] connIn,
	output logic [1:0] connOut,
	output logic [1:0] connOe_n,
	// Internal system signals
	input wire logic markerIn,
	input wire logic triggerOutIn,
	input wire logic clockOutIn,
	input wire logic syncOutIn,
	input wire logic settingsValid,
	// Results to the rest of the device
	output logic rfModulation,
	output logic nextSegment,
	output logic extTrigger,
	output logic extClock,
	output logic extSync
);
	pulse_gen_pkg::pulse_ctrl_s ctrl;
	pulse_gen_pkg::pulse_timing_s timing;
	logic [31:0] connCfg;
	logic [1:0] syncA;
	logic [1:0] syncB;
	logic [1:0] prevB;
	logic [1:0] riseEdge;
	logic [1:0] fallEdge;
	logic [1:0] actEdge;
	logic [3:0] role [2];
	logic [1:0] slopeFall;
	logic pgTrigEdge;
	logic gateActive;
	logic run;
	logic start;
	logic intPulse;
	logic busy;
	logic modLevel;

	// Register writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= '0;
			timing.period <= pulse_gen_pkg::PERIOD_RST;
			timing.width1 <= pulse_gen_pkg::WIDTH1_RST;
			timing.width2 <= pulse_gen_pkg::WIDTH2_RST;
			timing.delay2 <= pulse_gen_pkg::DELAY2_RST;
			connCfg <= {24'h00_000A, 8'h0A};
		end
		else if (regWr)
		begin
			case (regAddr)
				pulse_gen_pkg::REG_CTRL:
				begin
					ctrl.enable <= regWrData[pulse_gen_pkg::CTRL_ENABLE];
					ctrl.doublePulse <= regWrData[pulse_gen_pkg::CTRL_DOUBLE];
					ctrl.trigMode <= pulse_gen_pkg::trig_mode_e'(regWrData[pulse_gen_pkg::CTRL_TRIG_LO +: 2]);
					ctrl.extSource <= regWrData[pulse_gen_pkg::CTRL_EXTSRC];
					ctrl.modPolLow <= regWrData[pulse_gen_pkg::CTRL_MODPOL];
					ctrl.trigFalling <= regWrData[pulse_gen_pkg::CTRL_TRIGFALL];
					ctrl.gateLow <= regWrData[pulse_gen_pkg::CTRL_GATELOW];
				end
				pulse_gen_pkg::REG_PERIOD: timing.period <= regWrData;
				pulse_gen_pkg::REG_WIDTH1: timing.width1 <= regWrData;
				pulse_gen_pkg::REG_WIDTH2: timing.width2 <= regWrData;
				pulse_gen_pkg::REG_DELAY2: timing.delay2 <= regWrData;
				pulse_gen_pkg::REG_CONN: connCfg <= regWrData;
				default: ;
			endcase
		end
	end

	// Register reads, data one cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= '0;
		else if (regRd)
		begin
			case (regAddr)
				pulse_gen_pkg::REG_CTRL: regRdData <= {24'h00_0000, ctrl.gateLow, ctrl.trigFalling, ctrl.modPolLow,
					ctrl.extSource, ctrl.trigMode, ctrl.doublePulse, ctrl.enable};
				pulse_gen_pkg::REG_PERIOD: regRdData <= timing.period;
				pulse_gen_pkg::REG_WIDTH1: regRdData <= timing.width1;
				pulse_gen_pkg::REG_WIDTH2: regRdData <= timing.width2;
				pulse_gen_pkg::REG_DELAY2: regRdData <= timing.delay2;
				pulse_gen_pkg::REG_CONN: regRdData <= connCfg;
				pulse_gen_pkg::REG_STATUS: regRdData <= {28'h000_0000, syncB[1], busy,
					intPulse, rfModulation};
				default: regRdData <= pulse_gen_pkg::UNMAPPED;
			endcase
		end
		else
			regRdData <= '0;
	end

	// Two-stage synchronisers on the connector pins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA <= '0;
			syncB <= '0;
			prevB <= '0;
		end
		else
		begin
			syncA <= connIn;
			syncB <= syncA;
			prevB <= syncB;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_conn
			assign role[g] = connCfg[g*pulse_gen_pkg::CONN_FIELD +: 4];
			assign slopeFall[g] = connCfg[g*pulse_gen_pkg::CONN_FIELD + pulse_gen_pkg::CONN_SLOPE];
			assign riseEdge[g] = syncB[g] & ~prevB[g];
			assign fallEdge[g] = ~syncB[g] & prevB[g];
			assign actEdge[g] = slopeFall[g] ? fallEdge[g] : riseEdge[g];

			// Output drive per role; input roles leave the pin released
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					connOut[g] <= 1'b0;
					connOe_n[g] <= 1'b1;
				end
				else
				begin
					case (pulse_gen_pkg::conn_role_e'(role[g]))
						pulse_gen_pkg::ROLE_MARKER:
						begin
							connOut[g] <= markerIn;
							connOe_n[g] <= 1'b0;
						end
						pulse_gen_pkg::ROLE_VALID:
						begin
							connOut[g] <= settingsValid;
							connOe_n[g] <= 1'b0;
						end
						pulse_gen_pkg::ROLE_TRANSIT:
						begin
							connOut[g] <= ~settingsValid;
							connOe_n[g] <= 1'b0;
						end
						pulse_gen_pkg::ROLE_VIDEO:
						begin
							connOut[g] <= (g == 1) ? intPulse : 1'b0;
							connOe_n[g] <= (g == 1) ? 1'b0 : 1'b1;
						end
						default:
						begin
							connOut[g] <= 1'b0;
							connOe_n[g] <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate

	// Pulse-only roles are honoured on the second connector alone
	assign pgTrigEdge = (pulse_gen_pkg::conn_role_e'(role[1]) == pulse_gen_pkg::ROLE_PGTRIG)
		&& (ctrl.trigFalling ? fallEdge[1] : riseEdge[1]);
	assign gateActive = (pulse_gen_pkg::conn_role_e'(role[1]) == pulse_gen_pkg::ROLE_PGTRIG)
		&& (syncB[1] ^ ctrl.gateLow);

	// Trigger mode decides run and start
	always_comb
	begin
		run = 1'b0;
		start = 1'b0;
		case (ctrl.trigMode)
			pulse_gen_pkg::TRIG_AUTO:
			begin
				run = ctrl.enable;
				start = 1'b1;
			end
			pulse_gen_pkg::TRIG_SINGLE:
			begin
				run = ctrl.enable;
				start = pgTrigEdge && !busy;
			end
			pulse_gen_pkg::TRIG_GATED:
			begin
				run = ctrl.enable && gateActive;
				start = 1'b1;
			end
			default: ;
		endcase
	end

	pulse_core #(
		.CNT_W(CNT_W)
	) u_core (
		.clk(clk),
		.rst_n(rst_n),
		.run(run),
		.start(start),
		.doublePulse(ctrl.doublePulse),
		.timing(timing),
		.pulseOut(intPulse),
		.busy(busy)
	);

	// Modulation source: internal or external on connector two
	assign modLevel = (pulse_gen_pkg::conn_role_e'(role[1]) == pulse_gen_pkg::ROLE_MODSRC)
		&& (syncB[1] ^ ctrl.modPolLow);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rfModulation <= 1'b0;
			nextSegment <= 1'b0;
			extTrigger <= 1'b0;
			extClock <= 1'b0;
			extSync <= 1'b0;
		end
		else
		begin
			rfModulation <= ctrl.extSource ? modLevel : intPulse;
			nextSegment <= |(actEdge & {role[1] == 4'(pulse_gen_pkg::ROLE_NEXTSEG),
				role[0] == 4'(pulse_gen_pkg::ROLE_NEXTSEG)});
			extTrigger <= |(actEdge & {role[1] == 4'(pulse_gen_pkg::ROLE_TRIGGER),
				role[0] == 4'(pulse_gen_pkg::ROLE_TRIGGER)}) | triggerOutIn & 1'b0;
			extClock <= |(actEdge & {role[1] == 4'(pulse_gen_pkg::ROLE_CLOCK),
				role[0] == 4'(pulse_gen_pkg::ROLE_CLOCK)}) | clockOutIn & 1'b0;
			extSync <= |(syncB & {role[1] == 4'(pulse_gen_pkg::ROLE_SYNC),
				role[0] == 4'(pulse_gen_pkg::ROLE_SYNC)}) | syncOutIn & 1'b0;
		end
	end
endmodule // pulse_gen_router
`default_nettype wire

// ### testbench/pulse_gen_props.sv
// Port checker for the pulse generator and connector router
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	// Connectors
	input wire logic [1:0] connIn,
	input wire logic [1:0] connOut,
	input wire logic [1:0] connOe_n,
	// Device side
	input wire logic settingsValid,
	input wire logic rfModulation,
	input wire logic nextSegment,
	input wire logic extTrigger
);
	logic [15:0] conn;
	logic [7:0] ctrl;
	logic [2:0] age;
	logic ok;
	// Any write restarts the settle count, so routing changes are not judged mid-flight
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conn <= 16'h0A0A;
			ctrl <= 8'h00;
			age <= 3'h0;
		end
		else
		begin
			if (regWr && regAddr == 8'h14)
				conn <= regWrData[15:0];
			if (regWr && regAddr == 8'h00)
				ctrl <= regWrData[7:0];
			age <= regWr ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
		end
	end
	assign ok = age == 3'h7;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence validHeld;
		(ok && conn[3:0] == 4'h5 && settingsValid) [*4];
	endsequence
	sequence gateOff;
		(ok && ctrl[4:0] == 5'h09 && conn[11:8] == 4'h8 && connIn[1] == ctrl[7]) [*6];
	endsequence
	a_rd_idle: assert property (!regRd |=> regRdData == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_input_release: assert property (ok && (conn[3:0] == 4'h4 || conn[3:0] > 4'h6) |-> connOe_n[0])
		else $error("connector one driven in an input or unavailable role");
	a_marker_drive: assert property (ok && conn[3:0] == 4'h0 |-> !connOe_n[0])
		else $error("marker role not driving");
	a_valid_high: assert property (validHeld |-> connOut[0] && !connOe_n[0])
		else $error("valid role not high");
	a_trans_high: assert property ((ok && conn[3:0] == 4'h6 && !settingsValid) [*4] |-> connOut[0])
		else $error("transition role not high");
	a_seg_pulse: assert property (nextSegment |=> !nextSegment)
		else $error("advance request longer than one cycle");
	a_trig_pulse: assert property (extTrigger |=> !extTrigger)
		else $error("trigger pulse longer than one cycle");
	a_idle_dark: assert property (ok && !ctrl[0] && !ctrl[4] |-> !rfModulation)
		else $error("modulation active while disabled");
	a_gate_off: assert property (gateOff |-> !rfModulation)
		else $error("modulation active after gate closed");
endmodule // pulse_gen_props
bind pulse_gen_router pulse_gen_props u_props (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
	.regRdData, .connIn, .connOut, .connOe_n, .settingsValid, .rfModulation, .nextSegment, .extTrigger);
`default_nettype wire

// ### testbench/ext_source.sv
// Model of the outside trigger, gate or modulation source
`timescale 1ns/1ps
`default_nettype none
module ext_source (
	// Clock
	input wire logic clk,
	// Pattern: 0 low, 1 high, 2 square wave of 16 cycles
	input wire logic [1:0] pattern,
	// Connector drive
	output var logic pin
);
	logic [3:0] phase = 4'h0;
	initial pin = 1'b0;
	always @(posedge clk)
	begin
		phase <= phase + 4'h1;
		pin <= (pattern == 2'h2) ? phase[3] : pattern[0];
	end
endmodule // ext_source
`default_nettype wire

// ### testbench/tb_pulse_gen_router.sv
// Self-checking testbench for the pulse generator and connector router
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_pulse_gen_router;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	logic [1:0] connOut;
	logic [1:0] connOe_n;
	logic markerIn = 1'b0;
	logic settingsValid = 1'b0;
	logic rfModulation;
	logic nextSegment;
	logic extTrigger;
	logic extClock;
	logic extSync;
	logic rfPrev = 1'b0;
	logic pin0 = 1'b0;
	logic [1:0] pattern = 2'h0;
	wire logic pin1;
	wire logic [1:0] connIn;
	int fail_count = 0;
	int checks_done = 0;
	int rr = 0;
	int ns = 0;
	int et = 0;
	int ec = 0;
	int n;
	int m;
	assign connIn[0] = connOe_n[0] ? pin0 : connOut[0];
	assign connIn[1] = connOe_n[1] ? pin1 : connOut[1];
	ext_source src (.clk(clk), .pattern(pattern), .pin(pin1));
	pulse_gen_router dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .connIn(connIn), .connOut(connOut),
		.connOe_n(connOe_n), .markerIn(markerIn), .triggerOutIn(1'b0), .clockOutIn(1'b0),
		.syncOutIn(1'b0), .settingsValid(settingsValid), .rfModulation(rfModulation),
		.nextSegment(nextSegment), .extTrigger(extTrigger), .extClock(extClock), .extSync(extSync));
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		rfPrev <= rfModulation;
		rr <= rr + int'(rfModulation && !rfPrev);
		ns <= ns + int'(nextSegment);
		et <= et + int'(extTrigger);
		ec <= ec + int'(extClock);
	end
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rc(logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CK("regRdData", e, regRdData)
	endtask
	// Length of the current level of the modulation output, bounded
	task automatic len(output int k);
		logic l;
		l = rfModulation;
		k = 0;
		while (rfModulation === l && k < 400)
		begin
			tick(1);
			k++;
		end
	endtask
	task automatic sync_rise;
		len(n);
		if (rfModulation !== 1'b1)
			len(n);
	endtask
	task automatic t_regs;
		rc(8'h04, pulse_gen_pkg::PERIOD_RST);
		rc(8'h08, pulse_gen_pkg::WIDTH1_RST);
		rc(8'h0C, pulse_gen_pkg::WIDTH2_RST);
		rc(8'h10, pulse_gen_pkg::DELAY2_RST);
		rc(8'h00, 32'h0);
		rc(8'h14, 32'h0A0A);
		rc(8'h18, 32'h0);
		wr(8'h1C, 32'hFFFF_FFFF);
		rc(8'h1C, pulse_gen_pkg::UNMAPPED);
		$display("t_regs done");
	endtask
	task automatic t_auto;
		wr(8'h04, 32'h14);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'h1);
		sync_rise();
		len(n);
		`CK("width1", 5, n)
		len(m);
		`CK("gap", 15, m)
		len(n);
		`CK("width1 again", 5, n)
		$display("t_auto done");
	endtask
	task automatic t_double;
		// Stop first so the first rise seen is the first pulse of a period
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1E);
		wr(8'h08, 32'h4);
		wr(8'h0C, 32'h3);
		wr(8'h10, 32'hA);
		wr(8'h00, 32'h3);
		sync_rise();
		len(n);
		`CK("first", 4, n)
		len(n);
		`CK("to second", 6, n)
		len(n);
		`CK("second", 3, n)
		len(n);
		`CK("rest", 17, n)
		$display("t_double done");
	endtask
	task automatic t_single;
		wr(8'h14, 32'h080A);
		wr(8'h00, 32'h5);
		tick(40);
		n = rr;
		@(posedge clk) pattern <= 2'h1;
		tick(8);
		@(posedge clk) pattern <= 2'h0;
		tick(3);
		@(posedge clk) pattern <= 2'h1;
		tick(60);
		`CK("one shot", 1, rr - n)
		wr(8'h00, 32'h45);
		n = rr;
		@(posedge clk) pattern <= 2'h0;
		tick(40);
		@(posedge clk) pattern <= 2'h1;
		tick(40);
		`CK("falling shot", 1, rr - n)
		$display("t_single done");
	endtask
	task automatic t_gated;
		wr(8'h00, 32'h9);
		n = rr;
		tick(100);
		`CK("gate open", 1'b1, rr - n > 2)
		@(posedge clk) pattern <= 2'h0;
		tick(6);
		`CK("gate closed", 1'b0, rfModulation)
		n = rr;
		tick(60);
		`CK("no pulses", 0, rr - n)
		wr(8'h00, 32'h89);
		n = rr;
		tick(60);
		`CK("low gate", 1'b1, rr - n > 1)
		$display("t_gated done");
	endtask
	task automatic t_ext;
		wr(8'h14, 32'h090A);
		wr(8'h00, 32'h11);
		@(posedge clk) pattern <= 2'h1;
		tick(8);
		`CK("ext high", 1'b1, rfModulation)
		@(posedge clk) pattern <= 2'h0;
		tick(8);
		`CK("ext low", 1'b0, rfModulation)
		wr(8'h00, 32'h31);
		tick(8);
		`CK("inverted", 1'b1, rfModulation)
		@(posedge clk) pattern <= 2'h2;
		tick(4);
		n = rr;
		tick(64);
		`CK("ext pulses", 4, rr - n)
		$display("t_ext done");
	endtask
	task automatic t_conn;
		wr(8'h00, 32'h0);
		wr(8'h14, 32'h0A00);
		@(posedge clk) markerIn <= 1'b1;
		tick(6);
		`CK("marker", 2'b01, {connOe_n[0], connOut[0]})
		wr(8'h14, 32'h0A05);
		@(posedge clk) settingsValid <= 1'b1;
		tick(12);
		`CK("valid", 1'b1, connOut[0])
		wr(8'h14, 32'h0A06);
		tick(6);
		`CK("transition", 1'b0, connOut[0])
		@(posedge clk) settingsValid <= 1'b0;
		tick(12);
		`CK("in transition", 1'b1, connOut[0])
		@(posedge clk) settingsValid <= 1'b1;
		wr(8'h14, 32'h0A04);
		n = ns;
		@(posedge clk) pin0 <= 1'b1;
		tick(8);
		`CK("advance", 1, ns - n)
		wr(8'h14, 32'h0A07);
		tick(6);
		`CK("video on one", 1'b1, connOe_n[0])
		wr(8'h14, 32'h0A11);
		n = et;
		@(posedge clk) pin0 <= 1'b0;
		tick(8);
		@(posedge clk) pin0 <= 1'b1;
		tick(8);
		`CK("trig falling", 1, et - n)
		wr(8'h14, 32'h0A02);
		n = ec;
		@(posedge clk) pin0 <= 1'b0;
		tick(8);
		@(posedge clk) pin0 <= 1'b1;
		tick(8);
		`CK("clock rising", 1, ec - n)
		wr(8'h14, 32'h0A03);
		tick(4);
		`CK("sync level", 1'b1, extSync)
		wr(8'h14, 32'h0700);
		wr(8'h00, 32'h1);
		sync_rise();
		tick(1);
		`CK("video", 2'b01, {connOe_n[1], connOut[1]})
		$display("t_conn done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_auto();
		t_double();
		t_single();
		t_gated();
		t_ext();
		t_conn();
		stop_test();
	end
	// Tests need under 3000 cycles; a hung wait ends the run here
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule // tb_pulse_gen_router
`default_nettype wire
